// ### adc_readout_cfg.svh
// timing counts, widths and reset values of the dual converter readout
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH

// ==========================================================================
// clock and timing
`define CLOCK_HZ            20000000
`define HOLDOFF_MS          10
`define CONV_CYCLES         4'h2
`define COUNT_ZERO          4'h0
`define IDLE_LIMIT_DEFAULT  20000

// ==========================================================================
// frame and data
`define RESULT_BITS         16
`define RESULT_MSB          15
`define BIT_LAST            4'hf
`define BIT_FIRST           4'h0
`define RESULT_RESET        16'h0000
`define FIFO_DEPTH_DEFAULT  16
`define FIFO_WIDTH_DEFAULT  32

`endif

// ### adc_readout_pkg.sv
// shared types of the dual converter readout
`include "adc_readout_cfg.svh"

package adc_readout_pkg;

  // ========================================================================
  // one conversion result of both channels
  typedef struct packed {
    logic [`RESULT_MSB:0] ch1;
    logic [`RESULT_MSB:0] ch2;
  } result_type;

  // ========================================================================
  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_WAIT    = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_STORE   = 2'b11
  } conv_state_type;

endpackage

// ### result_fifo.sv
// single clock result fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "adc_readout_cfg.svh"

module result_fifo #(
  parameter int unsigned WIDTH = `FIFO_WIDTH_DEFAULT,
  parameter int unsigned DEPTH = `FIFO_DEPTH_DEFAULT
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  assign inReady  = (count_r != FULL_COUNT);
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // ==========================================================================
  // storage and pointers
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + PW'(1);
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + PW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + CW'(1);
      end else if (pop && !push) begin
        count_r <= count_r - CW'(1);
      end
    end
  end

  // ==========================================================================
  // checks
  a_full_refuses: assert property (@(posedge clock) disable iff (rst)
    (count_r == FULL_COUNT) |-> !inReady && outValid)
    else $error("fifo accepts while full");

  a_count_tracks: assert property (@(posedge clock) disable iff (rst)
    (push && !pop) |=> count_r == $past(count_r) + CW'(1))
    else $error("fifo count missed a push");

endmodule

`default_nettype wire

// ### dual_adc_readout.sv
// conversion sequencer and dual serial result readout
// Functional notes
// - strobe pin rising starts acquisition, sample-and-hold tracks the input
// - strobe pin falling freezes the sample and starts a conversion
// - each shift clock falling edge puts the next bit out, MSB first
// - echo clock toggles mid-bit of the data, launched from the rising edge of the same shift clock
// - echo clock is held off while the disable strap is tied high
// - reset at power-up and supply drop, then reinitialise with hold-off
// - results lag one conversion; first result after long idle is invalid
// - each channel has its own data line, both on one shift clock
`timescale 1ns/100ps
`default_nettype none
`include "adc_readout_cfg.svh"
module dual_adc_readout
  import adc_readout_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = `HOLDOFF_MS * (`CLOCK_HZ / 1000),
  parameter int unsigned IDLE_LIMIT     = `IDLE_LIMIT_DEFAULT,
  parameter int unsigned FIFO_DEPTH     = `FIFO_DEPTH_DEFAULT
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 shiftClock,
  input  wire logic                 conversionStrobeN,
  input  wire logic                 supplyLow,
  input  wire logic                 echoDisableStrap,
  input  wire logic [`RESULT_MSB:0] ch1Sample,
  input  wire logic [`RESULT_MSB:0] ch2Sample,
  output logic                      channel1ResultOut,
  output logic                      channel2ResultOut,
  output logic                      echoClock,
  output logic                      sampleMode,
  output logic                      initDone
);

  // ==========================================================================
  // declarations, system domain then link domain
  conv_state_type state_r;
  logic           strobeMeta_r;
  logic           strobeSync_r;
  logic           strobeLast_r;
  logic           supplyMeta_r;
  logic           supplyLowSync_r;
  logic           riseEdge;
  logic           fallEdge;
  logic           acqReq_r;
  logic [31:0]    holdCnt_r;
  logic [31:0]    idleCnt_r;
  logic [3:0]     convCnt_r;
  result_type     held_r;
  result_type     pending_r;
  result_type     txWord_r;
  logic           reqToggle_r;
  logic           ackMeta_r;
  logic           ackSync_r;
  logic           fifoInReady;
  logic           fifoOutValid;
  logic           fifoOutReady;
  logic [31:0]    fifoOutData;
  logic           pushing;
  logic             linkRstMeta_r;
  logic             linkRst_r;
  logic             reqMeta_r;
  logic             reqSync_r;
  logic             reqSeen_r;
  result_type       stage_r;
  logic [3:0]       bitCnt_r;
  logic [`RESULT_MSB:0] shift1_r;
  logic [`RESULT_MSB:0] shift2_r;
  logic             echoMeta_r;
  logic             echoOff_r;
  logic             echoClock_r;
  logic             ch1Out_r;
  logic             ch2Out_r;
  logic             sampleMode_r;
  logic             initDone_r;
  assign channel1ResultOut = ch1Out_r;
  assign channel2ResultOut = ch2Out_r;
  assign echoClock         = echoClock_r;
  assign sampleMode        = sampleMode_r;
  assign initDone          = initDone_r;
  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge clock) begin
    strobeMeta_r    <= conversionStrobeN;
    strobeSync_r    <= strobeMeta_r;
    strobeLast_r    <= strobeSync_r;
    supplyMeta_r    <= supplyLow;
    supplyLowSync_r <= supplyMeta_r;
  end
  assign riseEdge = strobeSync_r & ~strobeLast_r;
  assign fallEdge = ~strobeSync_r & strobeLast_r;
  // ==========================================================================
  // power-on hold-off
  // a supply dip restarts the whole wait, not just the remainder
  always_ff @(posedge clock) begin
    if (rst || supplyLowSync_r) begin
      holdCnt_r  <= '0;
      initDone_r <= 1'b0;
    end else if (!initDone_r) begin
      if (holdCnt_r >= HOLDOFF_CYCLES - 1) begin
        initDone_r <= 1'b1;
      end else begin
        holdCnt_r <= holdCnt_r + 32'h1;
      end
    end
  end

  // ==========================================================================
  // acquisition request, kept until the sequencer is free
  always_ff @(posedge clock) begin
    if (rst || supplyLowSync_r || !initDone_r) begin
      acqReq_r <= 1'b0;
    end else if (riseEdge && state_r != ST_WAIT) begin
      acqReq_r <= 1'b1;
    end else if (state_r == ST_WAIT) begin
      acqReq_r <= 1'b0;
    end
  end

  // ==========================================================================
  // conversion sequencer
  always_ff @(posedge clock) begin
    if (rst || supplyLowSync_r) begin
      state_r      <= ST_WAIT;
      sampleMode_r <= 1'b0;
      convCnt_r    <= `COUNT_ZERO;
    end else begin
      case (state_r)
        ST_WAIT: begin
          if (acqReq_r || (riseEdge && initDone_r)) begin
            state_r      <= ST_ACQUIRE;
            sampleMode_r <= 1'b1;
          end
        end
        ST_ACQUIRE: begin
          if (fallEdge) begin
            state_r      <= ST_CONVERT;
            sampleMode_r <= 1'b0;
            convCnt_r    <= `CONV_CYCLES - 4'h1;
          end
        end
        ST_CONVERT: begin
          if (convCnt_r == `COUNT_ZERO) begin
            state_r <= ST_STORE;
          end else begin
            convCnt_r <= convCnt_r - 4'h1;
          end
        end
        ST_STORE: begin
          // full fifo stalls the sequencer here
          if (fifoInReady) begin
            state_r <= ST_WAIT;
          end
        end
        default: begin
          state_r <= ST_WAIT;
        end
      endcase
    end
  end

  // ==========================================================================
  // sample-and-hold: tracks while acquiring, frozen otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      held_r <= '0;
    end else if (state_r == ST_ACQUIRE && !fallEdge) begin
      held_r.ch1 <= ch1Sample;
      held_r.ch2 <= ch2Sample;
    end
  end

  // ==========================================================================
  // one-conversion latency: push the previous result, keep this one
  assign pushing = (state_r == ST_STORE) && fifoInReady;
  always_ff @(posedge clock) begin
    if (rst || supplyLowSync_r) begin
      pending_r <= '0;
      idleCnt_r <= '0;
    end else if (pushing) begin
      pending_r <= held_r;
      idleCnt_r <= '0;
    end else if (state_r == ST_WAIT) begin
      if (idleCnt_r >= IDLE_LIMIT - 1) begin
        pending_r <= '0;
      end else begin
        idleCnt_r <= idleCnt_r + 32'h1;
      end
    end
  end

  result_fifo #(
    .WIDTH(`FIFO_WIDTH_DEFAULT),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock   (clock),
    .rst     (rst),
    .inValid (state_r == ST_STORE),
    .inReady (fifoInReady),
    .inData  (pending_r),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData (fifoOutData)
  );
  // ==========================================================================
  // word handshake toward the link domain
  // txWord_r stays still while a toggle is outstanding, so it crosses safely
  assign fifoOutReady = (reqToggle_r == ackSync_r);
  always_ff @(posedge clock) begin
    ackMeta_r <= reqSeen_r;
    ackSync_r <= ackMeta_r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txWord_r    <= '0;
      reqToggle_r <= 1'b0;
    end else if (fifoOutValid && fifoOutReady) begin
      txWord_r    <= fifoOutData;
      reqToggle_r <= ~reqToggle_r;
    end
  end

  // ==========================================================================
  // link domain: data launched on the falling shift clock edge
  always_ff @(negedge shiftClock) begin
    linkRstMeta_r <= rst;
    linkRst_r     <= linkRstMeta_r;
    reqMeta_r     <= reqToggle_r;
    reqSync_r     <= reqMeta_r;
  end

  always_ff @(negedge shiftClock) begin
    if (linkRst_r) begin
      reqSeen_r <= 1'b0;
      stage_r   <= '0;
    end else if (reqSync_r != reqSeen_r) begin
      stage_r   <= txWord_r;
      reqSeen_r <= reqSync_r;
    end
  end

  // stale staging is sent again if no new word arrived in time
  always_ff @(negedge shiftClock) begin
    if (linkRst_r) begin
      bitCnt_r <= `BIT_FIRST;
      shift1_r <= `RESULT_RESET;
      shift2_r <= `RESULT_RESET;
      ch1Out_r <= 1'b0;
      ch2Out_r <= 1'b0;
    end else begin
      bitCnt_r <= (bitCnt_r == `BIT_LAST) ? `BIT_FIRST : bitCnt_r + 4'h1;
      if (bitCnt_r == `BIT_FIRST) begin
        ch1Out_r <= stage_r.ch1[`RESULT_MSB];
        ch2Out_r <= stage_r.ch2[`RESULT_MSB];
        shift1_r <= {stage_r.ch1[`RESULT_MSB-1:0], 1'b0};
        shift2_r <= {stage_r.ch2[`RESULT_MSB-1:0], 1'b0};
      end else begin
        ch1Out_r <= shift1_r[`RESULT_MSB];
        ch2Out_r <= shift2_r[`RESULT_MSB];
        shift1_r <= {shift1_r[`RESULT_MSB-1:0], 1'b0};
        shift2_r <= {shift2_r[`RESULT_MSB-1:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // echo clock: toggles on the rising edge, mid-bit of each data bit
  always_ff @(posedge shiftClock) begin
    echoMeta_r <= echoDisableStrap;
    echoOff_r  <= echoMeta_r;
  end

  always_ff @(posedge shiftClock) begin
    if (linkRst_r || echoOff_r) begin
      echoClock_r <= 1'b0;
    end else begin
      echoClock_r <= ~echoClock_r;
    end
  end

  // ==========================================================================
  // checks
  a_rise_enters_acquire: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_WAIT && riseEdge && initDone_r && !supplyLowSync_r)
      |=> state_r == ST_ACQUIRE && sampleMode_r)
    else $error("strobe rise did not start acquisition");

  a_fall_starts_conv: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_ACQUIRE && fallEdge && !supplyLowSync_r)
      |=> state_r == ST_CONVERT && !sampleMode_r && $stable(held_r))
    else $error("strobe fall did not start conversion");

  a_conv_ends_store: assert property (@(posedge clock) disable iff (rst)
    (state_r == ST_CONVERT && convCnt_r == `COUNT_ZERO && !supplyLowSync_r)
      |=> state_r == ST_STORE)
    else $error("conversion did not finish on count");

  a_holdoff_blocks: assert property (@(posedge clock) disable iff (rst)
    !initDone_r |=> state_r == ST_WAIT && !sampleMode_r)
    else $error("conversion started during hold-off");

  a_supply_restarts: assert property (@(posedge clock) disable iff (rst)
    supplyLowSync_r |=> !initDone_r && holdCnt_r == '0 ##1 !initDone_r)
    else $error("supply drop did not restart hold-off");

  a_push_previous: assert property (@(posedge clock) disable iff (rst)
    pushing |=> pending_r == $past(held_r))
    else $error("pending result not replaced after push");

  a_shift_msb_first: assert property (@(negedge shiftClock) disable iff (linkRst_r)
    (!linkRst_r && bitCnt_r != `BIT_FIRST) |=> ch1Out_r == $past(shift1_r[`RESULT_MSB])
      && ch2Out_r == $past(shift2_r[`RESULT_MSB]))
    else $error("serial bit out of order");

  a_frame_load_both: assert property (@(negedge shiftClock) disable iff (linkRst_r)
    (!linkRst_r && bitCnt_r == `BIT_FIRST) |=> ch1Out_r == $past(stage_r.ch1[`RESULT_MSB])
      && ch2Out_r == $past(stage_r.ch2[`RESULT_MSB]) && bitCnt_r == 4'h1)
    else $error("frame start did not load both channels");

  a_frame_wraps: assert property (@(negedge shiftClock) disable iff (linkRst_r)
    (bitCnt_r == `BIT_LAST) |=> bitCnt_r == `BIT_FIRST)
    else $error("frame length is not sixteen bits");

  a_echo_disabled: assert property (@(posedge shiftClock) disable iff (linkRst_r)
    echoOff_r |=> !echoClock_r)
    else $error("echo clock runs while strapped off");

  a_echo_toggles: assert property (@(posedge shiftClock) disable iff (linkRst_r)
    !echoOff_r |=> echoClock_r != $past(echoClock_r))
    else $error("echo clock did not toggle");
endmodule
`default_nettype wire

// ### host_model.sv
// host side model: strobe driver and serial result capture
`timescale 1ns/100ps
`default_nettype none

module host_model (
  input  wire logic clock,
  input  wire logic channel1ResultOut,
  input  wire logic channel2ResultOut,
  input  wire logic echoClock,
  output logic      conversionStrobeN,
  output logic      shiftClock
);
  logic q1[$];
  logic q2[$];
  int   echoEdges = 0;

  initial begin
    conversionStrobeN = 1'b0;
    shiftClock        = 1'b0;
  end

  always @(echoClock) echoEdges++;

  // ==========================================================================
  // strobe: each level held two system clocks, far above the minimum width
  task automatic rise();
    @(posedge clock);
    #1 conversionStrobeN = 1'b1;
    repeat (2) @(posedge clock);
  endtask

  task automatic fall();
    @(posedge clock);
    #1 conversionStrobeN = 1'b0;
    repeat (2) @(posedge clock);
  endtask

  // ==========================================================================
  // shift clock runs only inside a burst and idles low
  task automatic shift(input int n);
    repeat (n) begin
      #3 shiftClock = 1'b1;
      q1.push_back(channel1ResultOut);
      q2.push_back(channel2ResultOut);
      #3 shiftClock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### dual_adc_readout_tb.sv
// self-checking testbench of the dual converter readout
`timescale 1ns/100ps
`default_nettype none

module dual_adc_readout_tb;
  import adc_readout_pkg::*;
  localparam int HOLD = 20;
  localparam int IDLE = 50;

  logic        clock;
  logic        rst;
  logic        supplyLow;
  logic        strap;
  logic [15:0] ch1Sample;
  logic [15:0] ch2Sample;
  wire logic   shiftClock;
  wire logic   conversionStrobeN;
  wire logic   channel1ResultOut;
  wire logic   channel2ResultOut;
  wire logic   echoClock;
  wire logic   sampleMode;
  wire logic   initDone;
  int          errCount  = 0;
  int          nCompared = 0;
  int          cyc       = 0;
  int          relCyc    = 0;

  always #25 clock = ~clock;
  always @(posedge clock) cyc++;

  dual_adc_readout #(.HOLDOFF_CYCLES(HOLD), .IDLE_LIMIT(IDLE)) u_dual_adc_readout (
    .clock(clock), .rst(rst), .shiftClock(shiftClock), .conversionStrobeN(conversionStrobeN),
    .supplyLow(supplyLow), .echoDisableStrap(strap), .ch1Sample(ch1Sample),
    .ch2Sample(ch2Sample), .channel1ResultOut(channel1ResultOut),
    .channel2ResultOut(channel2ResultOut), .echoClock(echoClock), .sampleMode(sampleMode),
    .initDone(initDone));

  host_model u_host_model (
    .clock(clock), .channel1ResultOut(channel1ResultOut),
    .channel2ResultOut(channel2ResultOut), .echoClock(echoClock),
    .conversionStrobeN(conversionStrobeN), .shiftClock(shiftClock));

  // ==========================================================================
  // shared helpers
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // sel 1 watches initDone, sel 0 watches sampleMode
  task automatic waitSig(input string what, input bit sel, input logic lvl, input int bound);
    int n;
    n = 0;
    while (((sel ? initDone : sampleMode) !== lvl) && n < bound) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= bound) begin
      errCount++;
      $display("Error %s expected %b seen timeout", what, lvl);
      printVerdict();
    end
  endtask

  function automatic bit hasWord(input logic [15:0] e1, input logic [15:0] e2);
    logic [15:0] w1;
    logic [15:0] w2;
    for (int i = 0; i + 16 <= u_host_model.q1.size(); i++) begin
      for (int b = 0; b < 16; b++) begin
        w1[15-b] = u_host_model.q1[i+b];
        w2[15-b] = u_host_model.q2[i+b];
      end
      if (w1 === e1 && w2 === e2) return 1'b1;
    end
    return 1'b0;
  endfunction

  // last 32 bits of both lines; all zero means an invalid word whatever the phase
  function automatic logic [63:0] tail();
    logic [63:0] t;
    int          n;
    n = u_host_model.q1.size();
    for (int b = 0; b < 32; b++) begin
      t[b]    = u_host_model.q1[n-1-b];
      t[32+b] = u_host_model.q2[n-1-b];
    end
    return t;
  endfunction

  task automatic convert(input logic [15:0] a, input logic [15:0] b);
    @(posedge clock);
    #1 ch1Sample = a;
    ch2Sample = b;
    u_host_model.rise();
    waitSig("sampleMode high", 1'b0, 1'b1, 12);
    u_host_model.fall();
    waitSig("sampleMode low", 1'b0, 1'b0, 12);
    ch1Sample = ~a;
    ch2Sample = ~b;
    repeat (4) @(posedge clock);
  endtask

  task automatic readBurst();
    u_host_model.q1.delete();
    u_host_model.q2.delete();
    u_host_model.shift(64);
  endtask

  // ==========================================================================
  // scenarios
  task automatic testHoldoff();
    int dt;
    u_host_model.rise();
    repeat (4) @(posedge clock);
    #1 check("sampleMode before init", 64'h0, {63'h0, sampleMode});
    u_host_model.fall();
    waitSig("initDone", 1'b1, 1'b1, HOLD + 5);
    dt = cyc - relCyc;
    check("holdoff length", 64'h1, {63'h0, (dt >= HOLD && dt <= HOLD + 1)});
    repeat (4) @(posedge clock);
    #1 check("early strobe forgotten", 64'h0, {63'h0, sampleMode});
    $display("test holdoff done");
  endtask

  task automatic testReadout();
    convert(16'h8001, 16'h7ffe);
    readBurst();
    check("first word after reset", 64'h0, tail());
    convert(16'hc35a, 16'h0f0f);
    readBurst();
    check("previous result", 64'h1, {63'h0, hasWord(16'h8001, 16'h7ffe)});
    check("current result held back", 64'h0, {63'h0, hasWord(16'hc35a, 16'h0f0f)});
    $display("test readout done");
  endtask

  task automatic testEcho();
    u_host_model.echoEdges = 0;
    u_host_model.shift(32);
    check("echo toggles", 64'h20, 64'(u_host_model.echoEdges));
    @(posedge clock);
    #1 strap = 1'b1;
    u_host_model.shift(4);
    u_host_model.echoEdges = 0;
    u_host_model.shift(32);
    check("echo off toggles", 64'h0, 64'(u_host_model.echoEdges));
    check("echo off level", 64'h0, {63'h0, echoClock});
    @(posedge clock);
    #1 strap = 1'b0;
    u_host_model.shift(4);
    $display("test echo done");
  endtask

  task automatic testIdle();
    repeat (IDLE + 10) @(posedge clock);
    convert(16'h1234, 16'hfedc);
    readBurst();
    check("first word after idle", 64'h0, tail());
    convert(16'h5555, 16'haaaa);
    readBurst();
    check("word after idle burst", 64'h1, {63'h0, hasWord(16'h1234, 16'hfedc)});
    $display("test idle done");
  endtask

  // link stopped: words pile up until the sequencer stalls, then drain
  task automatic testFill();
    for (int i = 0; i < 18; i++) begin
      convert(16'(i + 1), 16'(i + 100));
    end
    u_host_model.rise();
    repeat (8) @(posedge clock);
    #1 check("stall when full", 64'h0, {63'h0, sampleMode});
    u_host_model.q1.delete();
    u_host_model.q2.delete();
    u_host_model.shift(768);
    waitSig("remembered strobe", 1'b0, 1'b1, 20);
    u_host_model.fall();
    waitSig("sampleMode low", 1'b0, 1'b0, 12);
    check("oldest drained", 64'h1, {63'h0, hasWord(16'h0001, 16'h0064)});
    check("stalled drained", 64'h1, {63'h0, hasWord(16'h0011, 16'h0074)});
    $display("test fill done");
  endtask

  task automatic testSupply();
    int dt;
    @(posedge clock);
    #1 supplyLow = 1'b1;
    repeat (4) @(posedge clock);
    #1 check("initDone in brownout", 64'h0, {63'h0, initDone});
    supplyLow = 1'b0;
    relCyc = cyc;
    waitSig("initDone again", 1'b1, 1'b1, HOLD + 8);
    dt = cyc - relCyc;
    check("holdoff after brownout", 64'h1, {63'h0, (dt >= HOLD && dt <= HOLD + 4)});
    $display("test supply done");
  endtask

  // ==========================================================================
  // main sequence: link gets four falling edges while reset is held
  initial begin
    clock     = 1'b0;
    rst       = 1'b1;
    supplyLow = 1'b0;
    strap     = 1'b0;
    ch1Sample = 16'h0000;
    ch2Sample = 16'h0000;
    u_host_model.shift(4);
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    relCyc = cyc;
    testHoldoff();
    testReadout();
    testEcho();
    testIdle();
    testFill();
    testSupply();
    printVerdict();
  end
endmodule
`default_nettype wire
